// ==== include/eps_defines.vh ====
// Constants for the energy pulse shaper: register map, resets, timing.
// Assumes a 16-bit byte address on the plain register port.
`ifndef EPS_DEFINES_VH
`define EPS_DEFINES_VH

`define EPS_ADDR_W          16
`define EPS_REG_WIDTH_LIMIT 16'h210A
`define EPS_REG_SPACING     16'h210B
`define EPS_REG_POLARITY    16'h210C
`define EPS_REG_STATUS      16'h210D

`define EPS_RST_WIDTH_LIMIT 8'hFF
`define EPS_RST_SPACING     8'h00
`define EPS_RST_POLARITY    8'h00

`define EPS_POL_INV_BIT     0
`define EPS_WIDTH_NO_LIMIT  8'hFF

// Filter clock rate derived from the 200 MHz reference
`define EPS_FIR_DIV         8'h28
`define EPS_SPACING_SHIFT   2
`define EPS_QUEUE_DEPTH     4'h8
`define EPS_NUM_CH          4

`endif

// ==== core/eps_pulse_queue.v ====
// Pending-request counter for one pulse channel.
// Assumes push and pop are single-cycle strobes on the same clock.
module eps_pulse_queue (
   input  wire i_ref_clk,
   input  wire i_rst,
   input  wire i_flush,
   input  wire i_push,
   input  wire i_pop,
   output wire o_empty,
   output wire o_full
);
`include "eps_defines.vh"

   reg  [3:0] count_q;
   reg  [3:0] count_d;
   wire       do_push;
   wire       do_pop;

   // Requests arriving while full are dropped; depth covers a mux frame
   assign do_push = i_push & ~o_full;
   assign do_pop  = i_pop & ~o_empty;
   assign o_empty = (count_q == 4'h0);
   assign o_full  = (count_q == `EPS_QUEUE_DEPTH);

   always @* begin
      count_d = count_q;
      if (i_flush) begin
         count_d = 4'h0;
      end else if (do_push && !do_pop) begin
         count_d = count_q + 4'h1;
      end else if (do_pop && !do_push) begin
         count_d = count_q - 4'h1;
      end
   end

   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         count_q <= 4'h0;
      end else begin
         count_q <= count_d;
      end
   end

endmodule // eps_pulse_queue

// ==== core/eps_shaper.v ====
// Energy pulse shaper: queues, spaces, width-limits and polarises four
// metering pulse outputs.
// Assumes compute-engine requests are one-cycle pulses on i_ref_clk and
// the register port follows the single-cycle strobe protocol.
//
// Contract
// (R1) Active pulse capped at (2*width+1)*spacing filter-clock cycles.
// (R2) Spacing zero or width 255: no limiting, pulses have 50% duty.
// (R3) Consecutive output pulses start spacing*4 filter-clock cycles apart.
// (R4) Spacing zero bypasses the queue; requests drive the output at once.
// (R5) All four outputs active low; invert bit set makes them active high.
// (R6) Non-zero spacing queues requests, releasing each after spacing elapses; requests arriving while 8 are queued are dropped.
//
// Added by the designer: the strobed register port.
module eps_shaper (
   input  wire        i_ref_clk,
   input  wire        i_rst,
   input  wire [15:0] i_addr,
   input  wire [7:0]  i_wdata,
   input  wire        i_wr,
   input  wire        i_rd,
   output wire [7:0]  o_rdata,
   input  wire        i_real_energy_req,
   input  wire        i_reactive_energy_req,
   input  wire        i_aux_x_req,
   input  wire        i_aux_y_req,
   output wire        o_real_energy_pulse,
   output wire        o_reactive_energy_pulse,
   output wire        o_aux_pulse_x,
   output wire        o_aux_pulse_y
);
`include "eps_defines.vh"

   reg  [7:0]  width_limit_q;
   reg  [7:0]  spacing_q;
   reg  [7:0]  polarity_q;
   reg  [7:0]  rdata_q;
   reg  [7:0]  rdata_d;
   reg  [7:0]  fir_div_q;
   reg         fir_en_q;
   reg  [3:0]  out_q;
   wire [3:0]  req;
   wire [3:0]  act;
   wire [3:0]  q_empty;
   wire        bypass;
   wire        limited;
   wire        invert;
   wire [16:0] cap_len;
   wire [16:0] act_len;
   wire [9:0]  gap_len;

   // Active length in filter-clock cycles: (2*w+1)*t
   function [16:0] eps_cap;
      input [7:0] w;
      input [7:0] t;
      begin
         eps_cap = {8'h00, w, 1'b1} * {9'h000, t};
      end
   endfunction

   assign req     = {i_aux_y_req, i_aux_x_req,
                     i_reactive_energy_req, i_real_energy_req};
   assign bypass  = (spacing_q == 8'h00);                        // R4
   assign limited = !bypass &&
                    (width_limit_q != `EPS_WIDTH_NO_LIMIT);       // R2
   assign invert  = polarity_q[`EPS_POL_INV_BIT];
   assign cap_len = eps_cap(width_limit_q, spacing_q);           // R1
   assign gap_len = {spacing_q, 2'b00};                          // R3
   // Unlimited mode: active for half the spacing period
   assign act_len = limited ? cap_len : {8'h00, spacing_q, 1'b0}; // R2

   // Filter-clock enable divider
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         fir_div_q <= 8'h00;
         fir_en_q  <= 1'b0;
      end else if (fir_div_q == `EPS_FIR_DIV - 8'h01) begin
         fir_div_q <= 8'h00;
         fir_en_q  <= 1'b1;
      end else begin
         fir_div_q <= fir_div_q + 8'h01;
         fir_en_q  <= 1'b0;
      end
   end

   // Register writes
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         width_limit_q <= `EPS_RST_WIDTH_LIMIT;
         spacing_q     <= `EPS_RST_SPACING;
         polarity_q    <= `EPS_RST_POLARITY;
      end else if (i_wr) begin
         case (i_addr)
            `EPS_REG_WIDTH_LIMIT: begin
               width_limit_q <= i_wdata;
            end
            `EPS_REG_SPACING: begin
               spacing_q <= i_wdata;
            end
            `EPS_REG_POLARITY: begin
               polarity_q <= {7'h00, i_wdata[`EPS_POL_INV_BIT]};
            end
            default: begin
               width_limit_q <= width_limit_q;
            end
         endcase
      end
   end

   // Register reads; unmapped addresses return zero
   always @* begin
      rdata_d = 8'h00;
      if (i_rd) begin
         case (i_addr)
            `EPS_REG_WIDTH_LIMIT: rdata_d = width_limit_q;
            `EPS_REG_SPACING:     rdata_d = spacing_q;
            `EPS_REG_POLARITY:    rdata_d = polarity_q;
            `EPS_REG_STATUS:      rdata_d = {act, ~q_empty};
            default:              rdata_d = 8'h00;
         endcase
      end
   end

   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign o_rdata = rdata_q;

   genvar ch;
   generate
      for (ch = 0; ch < `EPS_NUM_CH; ch = ch + 1) begin : g_ch
         reg  [16:0] wid_q;
         reg  [9:0]  gap_q;
         reg         act_q;
         wire        pop;

         // Release only after spacing has run out and the pulse ended
         assign pop = !bypass && !q_empty[ch] &&
                      (gap_q == 10'h000) && !act_q;             // R6

         eps_pulse_queue u_queue (
            .i_ref_clk (i_ref_clk),
            .i_rst     (i_rst),
            .i_flush   (bypass),                                 // R4
            .i_push    (req[ch] & ~bypass),                      // R6
            .i_pop     (pop),
            .o_empty   (q_empty[ch]),
            .o_full    ()
         );

         always @(posedge i_ref_clk or posedge i_rst) begin
            if (i_rst) begin
               act_q <= 1'b0;
               wid_q <= 17'h0_0000;
               gap_q <= 10'h000;
            end else if (bypass) begin
               // Each request flips the level: regular requests give 50%
               if (req[ch]) begin
                  act_q <= ~act_q;                               // R4
               end
               wid_q <= 17'h0_0000;
               gap_q <= 10'h000;
            end else if (pop) begin
               act_q <= 1'b1;
               wid_q <= act_len;                                 // R1
               gap_q <= gap_len;                                 // R3
            end else if (fir_en_q) begin
               if (wid_q <= 17'h0_0001) begin
                  act_q <= 1'b0;                                 // R1
               end
               if (wid_q != 17'h0_0000) begin
                  wid_q <= wid_q - 17'h0_0001;
               end
               if (gap_q != 10'h000) begin
                  gap_q <= gap_q - 10'h001;                      // R3
               end
            end
         end

         assign act[ch] = act_q;
      end
   endgenerate

   // Output polarity, registered
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         out_q <= 4'hF;
      end else begin
         out_q <= invert ? act : ~act;                           // R5
      end
   end

   assign o_real_energy_pulse     = out_q[0];
   assign o_reactive_energy_pulse = out_q[1];
   assign o_aux_pulse_x           = out_q[2];
   assign o_aux_pulse_y           = out_q[3];

endmodule // eps_shaper

// ==== verif/eps_shaper_chk.sv ====
// Checker on the shaper ports, watching the real energy channel.
// Assumes a 40-clock filter tick; settings change while pins idle.
module eps_shaper_chk (
   input wire        i_ref_clk,
   input wire        i_rst,
   input wire [15:0] i_addr,
   input wire [7:0]  i_wdata,
   input wire        i_wr,
   input wire        i_real_energy_req,
   input wire        o_real_energy_pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] s_q, w_q;
   logic       inv_q;
   int         on_n, gap_n;
   wire        req = i_real_energy_req;
   wire        pin = o_real_energy_pulse;
   wire        act = pin == inv_q;
   wire        sp = i_wr && i_addr == 16'h210b;
   wire        pol = i_wr && i_addr == 16'h210c;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   always @(posedge i_ref_clk or posedge i_rst)
      if (i_rst) begin
         {s_q, w_q, inv_q} <= {8'h00, 8'hff, 1'b0};
         {on_n, gap_n} <= 0;
      end else begin
         if (sp)
            s_q <= i_wdata;
         if (i_wr && i_addr == 16'h210a)
            w_q <= i_wdata;
         if (pol)
            inv_q <= i_wdata[0];
         on_n <= act ? on_n + 1 : 0;
         // New spacing: the next release owes nothing to old pulses
         gap_n <= sp ? 100000 : (act && on_n == 0) ? 0 : gap_n + 1;
      end
   property p_cap; act && s_q != 0 && w_q != 8'hff
      |-> on_n <= (2 * w_q + 1) * s_q * 40 + 1; endproperty
   a_cap: assert property (p_cap) else $error("too wide");
   property p_half; $fell(act) && s_q != 0 && w_q == 8'hff
      |-> on_n inside {[(2 * s_q - 1) * 40 : 2 * s_q * 40 + 1]}; endproperty
   a_half: assert property (p_half) else $error("not half duty");
   property p_space; $rose(act) && s_q != 0
      |-> gap_n >= (4 * s_q - 1) * 40; endproperty
   a_space: assert property (p_space) else $error("too close");
   property p_byp; s_q == 0 && req |-> ##[1:2] $changed(pin); endproperty
   a_byp: assert property (p_byp) else $error("no bypass");
   property p_pol; pol && i_wdata[0] != inv_q |-> ##[1:2] $changed(pin);
   endproperty
   a_pol: assert property (p_pol) else $error("no invert");
   property p_rel; s_q != 0 && req && !act && gap_n > 4 * s_q * 40 + 40
      |-> ##[1:3] act; endproperty
   a_rel: assert property (p_rel) else $error("held");
endmodule // eps_shaper_chk
bind eps_shaper eps_shaper_chk u_chk (.i_ref_clk(i_ref_clk),
   .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_real_energy_req(i_real_energy_req),
   .o_real_energy_pulse(o_real_energy_pulse));

// ==== verif/eps_pulse_sink.sv ====
// Pin sink standing for the LEDs: counts pulses on each pin.
// Assumes pins change only after rising clock edges.
module eps_pulse_sink (
   input  wire       i_ref_clk,
   input  wire       i_inv,
   input  wire [3:0] i_pin,
   output int        o_cnt [4]
);
   timeunit 1ns;
   timeprecision 1ps;
   wire  [3:0] on = i_pin ~^ {4{i_inv}};
   logic [3:0] on_p = 4'h0;
   always @(posedge i_ref_clk) begin
      on_p <= on;
      for (int k = 0; k < 4; k++)
         if (on[k] && !on_p[k])
            o_cnt[k] <= o_cnt[k] + 1;
   end
endmodule // eps_pulse_sink

// ==== verif/energy_pulse_shaper_bench.sv ====
// Self-checking bench for the energy pulse shaper.
// Assumes a 200 MHz clock and a filter tick of 40 clocks.
module energy_pulse_shaper_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_ref_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, inv = 0;
   logic [15:0] i_addr = 16'h0000;
   logic [7:0]  i_wdata = 8'h00;
   logic [3:0]  req = 4'h0, lvl = 4'h0, m;
   wire  [7:0]  o_rdata;
   wire  [3:0]  pin;
   int          cnt [4], base [4];
   int          error_cnt = 0, num_checks = 0, cyc = 0, seed = 32302;
   always #2.5 i_ref_clk = ~i_ref_clk;
   eps_shaper dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_real_energy_req(req[0]), .i_reactive_energy_req(req[1]),
      .i_aux_x_req(req[2]), .i_aux_y_req(req[3]),
      .o_real_energy_pulse(pin[0]), .o_reactive_energy_pulse(pin[1]),
      .o_aux_pulse_x(pin[2]), .o_aux_pulse_y(pin[3]));
   eps_pulse_sink sink (.i_ref_clk(i_ref_clk), .i_inv(inv), .i_pin(pin),
      .o_cnt(cnt));
   task automatic chk(input logic [31:0] s, e);
      num_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD %0t saw %0h want %0h", $time, s, e);
      end
   endtask
   task automatic acc(input bit w, input logic [15:0] a, logic [7:0] d);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= w;
      i_rd <= !w;
      @(posedge i_ref_clk);
      i_wr <= 0;
      i_rd <= 0;
      #1 if (!w) chk(o_rdata, d);
   endtask
   task automatic fire(input logic [3:0] v);
      @(posedge i_ref_clk);
      req <= v;
      @(posedge i_ref_clk);
      req <= 4'h0;
   endtask
   task automatic shape(input int s, w, n);
      acc(1, 16'h210b, s[7:0]);
      acc(1, 16'h210a, w[7:0]);
      base = cnt;
      repeat (n) fire(4'hf);
      // Lone request: released at once, queue empty, pulse still active
      if (n == 1) acc(0, 16'h210d, 8'hf0);
      repeat ((4 * n + 4) * s * 40) @(posedge i_ref_clk);
      // Depth 8 plus the one released at once; later requests dropped
      for (int k = 0; k < 4; k++)
         chk(cnt[k] - base[k], n > 9 ? 9 : n);
      acc(0, 16'h210d, 8'h00);
      $display("spacing %0d width %0d done", s, w);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge i_ref_clk)
      if (++cyc == 20000) begin
         error_cnt++;
         final_report();
      end
   initial begin
      repeat (16) @(posedge i_ref_clk);
      i_rst <= 0;
      acc(0, 16'h210a, 8'hff);
      acc(0, 16'h210b, 8'h00);
      acc(0, 16'h210c, 8'h00);
      acc(0, 16'h2100, 8'h00);
      chk(pin, 4'hf);
      m = $random(seed);
      acc(1, 16'h210a, {m, ~m});
      acc(0, 16'h210a, {m, ~m});
      // Read data stand one cycle only
      @(posedge i_ref_clk);
      #1 chk(o_rdata, 8'h00);
      acc(1, 16'h210c, 8'hff);
      acc(0, 16'h210c, 8'h01);
      inv = 1;
      $display("register test done");
      for (int k = 0; k < 8; k++) begin
         if (k == 4) begin
            acc(1, 16'h210c, 8'h00);
            inv = 0;
         end
         m = $random(seed);
         fire(m);
         lvl ^= m;
         repeat (2) @(posedge i_ref_clk);
         #1 chk(pin, lvl ^ {4{~inv}});
      end
      // Return every pin to idle before spacing is switched on
      fire(lvl);
      $display("bypass test done");
      shape(1, 0, 5);
      shape(1, 0, 10);
      shape(1, 1, 2);
      shape(2, 255, 1);
      final_report();
   end
endmodule // energy_pulse_shaper_bench
